// File: design/typeb_defs.vh
// Constants for the Type B answer builder and selection command decoder.
`ifndef TYPEB_DEFS_VH
`define TYPEB_DEFS_VH
`define ANS_CODE 8'h50
`define SEL_CODE 8'h1d
`define APP_DATA_BYTE 8'h00
`define PROTO_BYTE1 8'h91
`define PROTO_BYTE2 8'h81
`define PROTO3_LOW 4'h0
`define ANS_LEN 4'hd
`define SEL_LEN 4'hb
`define SEL_ID_FIRST 4'h1
`define SEL_P1_POS 4'h5
`define SEL_P2_POS 4'h6
`define SEL_P3_POS 4'h7
`define SEL_P4_POS 4'h8
`define P1_TR0_HI 7
`define P1_TR0_LO 6
`define P1_TR1_HI 5
`define P1_TR1_LO 4
`define P1_EOF_BIT 3
`define P1_SOF_BIT 2
`define P2_FSD_OK_MAX 4'h8
`define P2_FSD_OK_MIN 4'h5
`define P3_EXPECT 8'h01
`define P4_CID_NONE 4'h0
`define TR_CODE_RSVD 2'h3
`define TR_CODE_DEF 2'h0
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
`define CRC_RESIDUE 16'hf0b8
`define TR0_MIN_FS 8'd64
`define TR1_MIN_FS 8'd80
`define TR2_ETU 8'd10
`define TR2_FS 8'd32
`endif

// File: design/crc_b_byte.v
// Reflected CRC_B update over one byte.
`timescale 1ns/1ps
module crc_b_byte (
    input wire [15:0] crc_i, // Running value.
    input wire [7:0] data_i, // Byte to fold in.
    output wire [15:0] crc_o // Updated value.
);
`include "typeb_defs.vh"
    wire [15:0] stage [0:8];
    assign stage[0] = crc_i ^ {8'h00, data_i};
    genvar k;
    // One shift per bit, least significant bit first.
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_bit
            assign stage[k + 1] = stage[k][0] ?
                ((stage[k] >> 1) ^ `CRC_POLY) : (stage[k] >> 1);
        end
    endgenerate
    assign crc_o = stage[8];
endmodule

// File: design/typeb_atqb_attrib_handler.v
// Type B answer builder and selection command first-part decoder.
`timescale 1ns/1ps
// Overview of operation
// (RL1) Answer: 0x50, id, app data, info, CRC.
// (RL2) Application data bytes are always zero.
// (RL3) First protocol info byte is 0x91.
// (RL4) Second protocol info byte is 0x81.
// (RL5) Reader waits TR2 after tag answers.
// (RL6) Third info byte: FWI high, zero low.
// (RL7) Third info byte bits 3-2 are 00b.
// (RL8) Third info byte bits 1-0 are 00b.
// (RL9) Selection: 0x1d, id, four params, CRC.
// (RL10) Valid addressed selection enters active state.
// (RL11) TR0 decoded; device keeps 64/fs minimum.
// (RL12) TR1 decoded; device keeps 80/fs minimum.
// (RL13) Reserved 11b reads as 00b; bits 1-0 ignored.
// (RL14) Omission requests noted; delimiters still sent.
// (RL15) Unsupported parameters: stay silent.
// (RL16) Frames carry CRC_B; bad frames dropped.
module typeb_atqb_attrib_handler (
    input wire REF_CLK_I, // 20 MHz clock.
    input wire RESET_N_I, // Async reset, active low.
    input wire RX_VALID_I, // Received byte strobe.
    input wire [7:0] RX_DATA_I, // Received byte.
    input wire RX_SOF_I, // Pulse marking frame start.
    input wire RX_EOF_I, // Pulse marking frame end.
    input wire ANS_REQ_I, // Pulse: request decoded, send answer.
    input wire [31:0] CARD_ID_I, // Stored card identifier.
    input wire [3:0] FWI_I, // Frame waiting time integer.
    input wire TX_READY_I, // Transmitter takes a byte.
    input wire STATE_CLR_I, // Pulse: leave active state; ignored in a cycle with RX_SOF_I, RX_VALID_I or a selection RX_EOF_I.
    output wire TX_VALID_O, // Byte offered to transmitter.
    output reg [7:0] TX_DATA_O, // Byte to transmit.
    output wire TX_LAST_O, // Offered byte ends the frame.
    output wire TX_SOF_EN_O, // Send start delimiter.
    output wire TX_EOF_EN_O, // Send end delimiter.
    output reg SEL_OK_O, // Pulse: selection accepted.
    output reg SEL_REJECT_O, // Pulse: selection dropped.
    output reg ACTIVE_O, // Protocol active state flag.
    output reg [1:0] TR0_CODE_O, // Decoded TR0 code.
    output reg [1:0] TR1_CODE_O, // Decoded TR1 code.
    output reg EOF_OMIT_REQ_O, // Reader asked to omit EOF.
    output reg SOF_OMIT_REQ_O, // Reader asked to omit SOF.
    output reg [7:0] TR0_MIN_FS_O, // Applied TR0 in 1/fs.
    output reg [7:0] TR1_MIN_FS_O // Applied TR1 in 1/fs.
);
`include "typeb_defs.vh"
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SEND = 3'b010;
    localparam [2:0] ST_CRC = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [3:0] tx_idx_reg;
    reg [15:0] tx_crc_reg;
    reg [31:0] id_snap_reg;
    reg [3:0] fwi_snap_reg;
    reg [7:0] body_byte;
    wire [15:0] tx_crc_upd;
    wire [15:0] tx_crc_out;

    // Both delimiters are always sent, whatever the reader asked. [RL14]
    assign TX_SOF_EN_O = 1'b1;
    assign TX_EOF_EN_O = 1'b1;

    // Body byte chooser for the identification answer.
    always @* begin
        case (tx_idx_reg)
            4'h0: body_byte = `ANS_CODE; // [RL1]
            4'h1: body_byte = id_snap_reg[7:0];
            4'h2: body_byte = id_snap_reg[15:8];
            4'h3: body_byte = id_snap_reg[23:16];
            4'h4: body_byte = id_snap_reg[31:24];
            4'h5, 4'h6, 4'h7, 4'h8: body_byte = `APP_DATA_BYTE; // [RL2]
            4'h9: body_byte = `PROTO_BYTE1; // [RL3]
            4'ha: body_byte = `PROTO_BYTE2; // [RL4]
            // FWI high, coding and option bits all zero. [RL6] [RL7] [RL8]
            4'hb: body_byte = {fwi_snap_reg, `PROTO3_LOW};
            default: body_byte = 8'h00;
        endcase
    end

    crc_b_byte u_tx_crc (
        .crc_i(tx_crc_reg),
        .data_i(body_byte),
        .crc_o(tx_crc_upd)
    );
    // Transmitted CRC is the complement, low byte first. [RL16]
    assign tx_crc_out = ~tx_crc_reg;

    // Data output is combinational from registered index and snapshot.
    always @* begin
        if (state_reg == ST_CRC) begin
            TX_DATA_O = tx_idx_reg[0] ? tx_crc_out[15:8] : tx_crc_out[7:0];
        end else begin
            TX_DATA_O = body_byte;
        end
    end
    assign TX_VALID_O = (state_reg == ST_SEND) || (state_reg == ST_CRC);
    assign TX_LAST_O = (state_reg == ST_CRC) && tx_idx_reg[0];

    // Answer sequencer; a new request during an answer is ignored.
    always @* begin
        case (state_reg)
            ST_IDLE: begin
                state_next = ANS_REQ_I ? ST_SEND : ST_IDLE;
            end
            ST_SEND: begin
                if (TX_READY_I && tx_idx_reg == `ANS_LEN - 4'h2) begin
                    state_next = ST_CRC;
                end else begin
                    state_next = ST_SEND;
                end
            end
            ST_CRC: begin
                if (TX_READY_I && tx_idx_reg[0]) begin
                    state_next = ST_IDLE;
                end else begin
                    state_next = ST_CRC;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Answer byte counter, CRC accumulation and field snapshots.
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_reg <= ST_IDLE;
            tx_idx_reg <= 4'h0;
            tx_crc_reg <= `CRC_INIT;
            id_snap_reg <= 32'h00000000;
            fwi_snap_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            case (state_reg)
                ST_IDLE: begin
                    tx_idx_reg <= 4'h0;
                    tx_crc_reg <= `CRC_INIT;
                    // Snapshot so the answer cannot tear mid-frame.
                    id_snap_reg <= CARD_ID_I;
                    fwi_snap_reg <= FWI_I;
                end
                ST_SEND: begin
                    if (TX_READY_I) begin
                        tx_crc_reg <= tx_crc_upd;
                        if (tx_idx_reg == `ANS_LEN - 4'h2) begin
                            tx_idx_reg <= 4'h0;
                        end else begin
                            tx_idx_reg <= tx_idx_reg + 4'h1;
                        end
                    end
                end
                ST_CRC: begin
                    if (TX_READY_I) begin
                        tx_idx_reg <= tx_idx_reg + 4'h1;
                    end
                end
                default: tx_idx_reg <= 4'h0;
            endcase
        end
    end

    // Receive side: selection command collector.
    reg [3:0] rx_cnt_reg;
    reg [15:0] rx_crc_reg;
    reg rx_is_sel_reg;
    reg rx_id_ok_reg;
    reg rx_par_ok_reg;
    reg [7:0] p1_reg;
    wire [15:0] rx_crc_upd;
    wire [1:0] tr0_raw;
    wire [1:0] tr1_raw;
    wire byte_id_ok;
    wire byte_par_ok;
    wire [1:0] rate_up;
    wire [1:0] rate_dn;

    crc_b_byte u_rx_crc (
        .crc_i(rx_crc_reg),
        .data_i(RX_DATA_I),
        .crc_o(rx_crc_upd)
    );

    // Identifier byte compare, low byte first. [RL9] [RL10]
    assign byte_id_ok =
        (rx_cnt_reg == `SEL_ID_FIRST) ? (RX_DATA_I == CARD_ID_I[7:0]) :
        (rx_cnt_reg == 4'h2) ? (RX_DATA_I == CARD_ID_I[15:8]) :
        (rx_cnt_reg == 4'h3) ? (RX_DATA_I == CARD_ID_I[23:16]) :
        (rx_cnt_reg == 4'h4) ? (RX_DATA_I == CARD_ID_I[31:24]) : 1'b1;

    // Parameter support check for Param2 to Param4. [RL15]
    assign rate_up = RX_DATA_I[7:6];
    assign rate_dn = RX_DATA_I[5:4];
    assign byte_par_ok =
        (rx_cnt_reg == `SEL_P2_POS) ?
            ((rate_up == rate_dn) && !rate_up[1] &&
             (RX_DATA_I[3:0] <= `P2_FSD_OK_MAX) &&
             (RX_DATA_I[3:0] >= `P2_FSD_OK_MIN)) :
        (rx_cnt_reg == `SEL_P3_POS) ? (RX_DATA_I == `P3_EXPECT) :
        (rx_cnt_reg == `SEL_P4_POS) ? (RX_DATA_I[3:0] == `P4_CID_NONE) :
        1'b1;

    // Reserved 11b codes fold to 00b; bits 1-0 are never looked at.
    assign tr0_raw = p1_reg[`P1_TR0_HI:`P1_TR0_LO];
    assign tr1_raw = p1_reg[`P1_TR1_HI:`P1_TR1_LO];

    // Frame collector and end-of-frame verdict.
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rx_cnt_reg <= 4'h0;
            rx_crc_reg <= `CRC_INIT;
            rx_is_sel_reg <= 1'b0;
            rx_id_ok_reg <= 1'b0;
            rx_par_ok_reg <= 1'b0;
            p1_reg <= 8'h00;
            SEL_OK_O <= 1'b0;
            SEL_REJECT_O <= 1'b0;
            ACTIVE_O <= 1'b0;
            TR0_CODE_O <= `TR_CODE_DEF;
            TR1_CODE_O <= `TR_CODE_DEF;
            EOF_OMIT_REQ_O <= 1'b0;
            SOF_OMIT_REQ_O <= 1'b0;
            TR0_MIN_FS_O <= `TR0_MIN_FS;
            TR1_MIN_FS_O <= `TR1_MIN_FS;
        end else begin
            SEL_OK_O <= 1'b0;
            SEL_REJECT_O <= 1'b0;
            // Applied minimum delays never shrink. [RL11] [RL12]
            TR0_MIN_FS_O <= `TR0_MIN_FS;
            TR1_MIN_FS_O <= `TR1_MIN_FS;
            if (RX_SOF_I) begin
                rx_cnt_reg <= 4'h0;
                rx_crc_reg <= `CRC_INIT;
                rx_is_sel_reg <= 1'b0;
                rx_id_ok_reg <= 1'b1;
                rx_par_ok_reg <= 1'b1;
            end else if (RX_VALID_I) begin
                rx_crc_reg <= rx_crc_upd;
                if (rx_cnt_reg != 4'hf) begin
                    rx_cnt_reg <= rx_cnt_reg + 4'h1;
                end
                if (rx_cnt_reg == 4'h0) begin
                    rx_is_sel_reg <= (RX_DATA_I == `SEL_CODE); // [RL9]
                end
                if (rx_cnt_reg == `SEL_P1_POS) begin
                    p1_reg <= RX_DATA_I;
                end
                rx_id_ok_reg <= rx_id_ok_reg && byte_id_ok;
                rx_par_ok_reg <= rx_par_ok_reg && byte_par_ok;
            end else if (RX_EOF_I && rx_is_sel_reg) begin
                // The check bytes are sent complemented, so a good frame
                // leaves the fixed residue rather than zero.
                if (rx_cnt_reg == `SEL_LEN && rx_crc_reg == `CRC_RESIDUE &&
                    rx_id_ok_reg) begin // [RL16]
                    if (rx_par_ok_reg) begin
                        SEL_OK_O <= 1'b1;
                        ACTIVE_O <= 1'b1; // [RL10]
                        TR0_CODE_O <= (tr0_raw == `TR_CODE_RSVD) ?
                            `TR_CODE_DEF : tr0_raw; // [RL13]
                        TR1_CODE_O <= (tr1_raw == `TR_CODE_RSVD) ?
                            `TR_CODE_DEF : tr1_raw; // [RL13]
                        EOF_OMIT_REQ_O <= p1_reg[`P1_EOF_BIT]; // [RL14]
                        SOF_OMIT_REQ_O <= p1_reg[`P1_SOF_BIT]; // [RL14]
                    end else begin
                        // Silent drop: no answer is ever queued. [RL15]
                        SEL_REJECT_O <= 1'b1;
                    end
                end
                rx_is_sel_reg <= 1'b0;
            end else if (STATE_CLR_I) begin
                ACTIVE_O <= 1'b0;
            end
        end
    end
endmodule

// File: tb/typeb_atqb_attrib_handler_chk.sv
// Port checker for the Type B answer builder and selection decoder.
`timescale 1ns/1ps
module typeb_atqb_attrib_handler_chk (
    input wire REF_CLK_I, // Clock.
    input wire RESET_N_I, // Reset, active low.
    input wire RX_EOF_I, // Frame end pulse.
    input wire ANS_REQ_I, // Answer request.
    input wire TX_READY_I, // Byte taken.
    input wire [3:0] FWI_I, // Waiting time integer.
    input wire TX_VALID_O, // Byte offered.
    input wire [7:0] TX_DATA_O, // Offered byte.
    input wire TX_LAST_O, // Final byte.
    input wire TX_SOF_EN_O, // Start delimiter on.
    input wire TX_EOF_EN_O, // End delimiter on.
    input wire SEL_OK_O, // Accept pulse.
    input wire SEL_REJECT_O, // Reject pulse.
    input wire ACTIVE_O, // Active state.
    input wire [1:0] TR0_CODE_O, // TR0 code.
    input wire [1:0] TR1_CODE_O, // TR1 code.
    input wire [7:0] TR0_MIN_FS_O, // Applied TR0.
    input wire [7:0] TR1_MIN_FS_O // Applied TR1.
);
    reg [3:0] idx_reg;
    // Index of the offered answer byte; restarts whenever the path idles.
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) idx_reg <= 4'h0;
        else if (!TX_VALID_O) idx_reg <= 4'h0;
        else if (TX_READY_I) idx_reg <= idx_reg + 4'h1;
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_ans_go;
        ANS_REQ_I && !TX_VALID_O;
    endsequence
    sequence s_ans_first;
        TX_VALID_O && TX_DATA_O == 8'h50;
    endsequence
    a_ans_start: assert property (s_ans_go |=> s_ans_first)
        else $error("answer did not open with its code");
    a_hold_byte: assert property (TX_VALID_O && !TX_READY_I |=>
        TX_VALID_O && $stable(TX_DATA_O)) else $error("byte not held");
    a_app_zero: assert property (TX_VALID_O && idx_reg >= 4'h5 &&
        idx_reg <= 4'h8 |-> TX_DATA_O == 8'h00) else $error("app data");
    a_info_one: assert property (TX_VALID_O && idx_reg == 4'h9 |->
        TX_DATA_O == 8'h91) else $error("first info byte wrong");
    a_info_two: assert property (TX_VALID_O && idx_reg == 4'ha |->
        TX_DATA_O == 8'h81) else $error("second info byte wrong");
    a_info_fwi: assert property (TX_VALID_O && idx_reg == 4'hb |->
        TX_DATA_O == {FWI_I, 4'h0}) else $error("third info byte wrong");
    a_last_byte: assert property (TX_VALID_O |->
        TX_LAST_O == (idx_reg == 4'hd)) else $error("last flag misplaced");
    a_delims_kept: assert property (TX_SOF_EN_O && TX_EOF_EN_O)
        else $error("frame delimiter dropped");
    a_min_fixed: assert property (TR0_MIN_FS_O == 8'h40 &&
        TR1_MIN_FS_O == 8'h50) else $error("applied minimum changed");
    a_no_rsvd: assert property (TR0_CODE_O != 2'h3 &&
        TR1_CODE_O != 2'h3) else $error("reserved code passed on");
    a_ok_active: assert property (SEL_OK_O |-> ACTIVE_O)
        else $error("accept without active state");
    a_verdict_time: assert property (SEL_OK_O || SEL_REJECT_O |->
        $past(RX_EOF_I)) else $error("verdict not after frame end");
    a_reject_hold: assert property (SEL_REJECT_O |-> $stable(ACTIVE_O)
        && $stable(TR0_CODE_O)) else $error("reject changed state");
endmodule

// File: tb/reader_model.sv
// Reader model: sends selection frames and collects answer bytes.
`timescale 1ns/1ps
module reader_model (
    input wire clk_i, // Clock.
    input wire tx_valid_i, // Answer byte offered.
    input wire [7:0] tx_data_i, // Answer byte.
    input wire slow_i, // Stall the answer path.
    output reg rx_valid_o, // Byte strobe.
    output reg [7:0] rx_data_o, // Frame byte.
    output reg rx_sof_o, // Frame start.
    output reg rx_eof_o, // Frame end.
    output reg tx_ready_o // Takes answer byte.
);
    // Ten etu plus 32/fs at 20 MHz, rounded up.
    localparam TR2_CYC = 2650;
    reg [7:0] fr [0:15];
    reg [7:0] ans [0:15];
    integer n_ans = 0, gap = TR2_CYC;
    initial begin
        {rx_valid_o, rx_sof_o, rx_eof_o, tx_ready_o} = 4'h1;
        rx_data_o = 8'h00;
    end
    // Takes answer bytes and times the quiet gap after each answer.
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) ans[n_ans[3:0]] <= tx_data_i;
        if (tx_valid_i && tx_ready_o) n_ans <= n_ans + 1;
        gap <= tx_valid_i ? 0 : gap + 1;
        tx_ready_o <= #1 slow_i ? ~tx_ready_o : 1'b1;
    end
    function [15:0] crcb(input [15:0] c, input [7:0] d);
        integer i;
        begin
            c = c ^ {8'h00, d};
            for (i = 0; i < 8; i = i + 1) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
            crcb = c;
        end
    endfunction
    // Sends n bytes of fr with CRC_B appended; bad spoils the check value.
    task send(input integer n, input bad);
        reg [15:0] c;
        integer i;
        begin
            while (gap < TR2_CYC) @(posedge clk_i);
            c = 16'hffff;
            for (i = 0; i < n; i = i + 1) c = crcb(c, fr[i]);
            c = ~c ^ {15'h0, bad};
            fr[n] = c[7:0];
            fr[n + 1] = c[15:8];
            @(posedge clk_i) #1 rx_sof_o = 1'b1;
            for (i = 0; i < n + 2; i = i + 1) begin
                @(posedge clk_i) #1 rx_sof_o = 1'b0;
                rx_valid_o = 1'b1;
                rx_data_o = fr[i];
            end
            @(posedge clk_i) #1 rx_valid_o = 1'b0;
            rx_data_o = ~rx_data_o; // A released line keeps no stale byte.
            rx_eof_o = 1'b1;
            @(posedge clk_i) #1 rx_eof_o = 1'b0;
        end
    endtask
endmodule

// File: tb/tb_typeb_atqb_attrib_handler.sv
// Self-checking bench for the Type B answer and selection block.
`timescale 1ns/1ps
module tb_typeb_atqb_attrib_handler;
    reg ref_clk, reset_n, ans_req, state_clr, slow;
    reg [31:0] card_id;
    reg [3:0] fwi;
    wire rx_valid, rx_sof, rx_eof, tx_ready, tx_valid, tx_last, sof_en;
    wire eof_en, sel_ok, sel_rej, active, eof_omit, sof_omit;
    wire [7:0] rx_data, tx_data, tr0_min, tr1_min;
    wire [1:0] tr0, tr1;
    integer n_mismatch = 0, check_count = 0, n_ok = 0, n_rej = 0, i, k;
    reg [13:0] rows [0:4];
    typeb_atqb_attrib_handler u_dut (.REF_CLK_I(ref_clk),
        .RESET_N_I(reset_n), .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data),
        .RX_SOF_I(rx_sof), .RX_EOF_I(rx_eof), .ANS_REQ_I(ans_req),
        .CARD_ID_I(card_id), .FWI_I(fwi), .TX_READY_I(tx_ready),
        .STATE_CLR_I(state_clr), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data),
        .TX_LAST_O(tx_last), .TX_SOF_EN_O(sof_en), .TX_EOF_EN_O(eof_en),
        .SEL_OK_O(sel_ok), .SEL_REJECT_O(sel_rej), .ACTIVE_O(active),
        .TR0_CODE_O(tr0), .TR1_CODE_O(tr1), .EOF_OMIT_REQ_O(eof_omit),
        .SOF_OMIT_REQ_O(sof_omit), .TR0_MIN_FS_O(tr0_min),
        .TR1_MIN_FS_O(tr1_min));
    reader_model u_rdr (.clk_i(ref_clk), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .slow_i(slow), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .rx_sof_o(rx_sof), .rx_eof_o(rx_eof),
        .tx_ready_o(tx_ready));
    // Free-running 20 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Counts verdict pulses so each frame's outcome can be read back.
    always @(posedge ref_clk) begin
        n_ok <= n_ok + (sel_ok === 1'b1);
        n_rej <= n_rej + (sel_rej === 1'b1);
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task complete_run;
        begin
            $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    // One selection frame; P3 always carries the supported protocol type.
    task sel(input [7:0] p1, p2, p4, input [31:0] id, input integer n,
             input bad, input integer eok, erej);
        integer o, r;
        begin
            o = n_ok;
            r = n_rej;
            u_rdr.fr[0] = 8'h1d;
            for (i = 0; i < 4; i = i + 1) u_rdr.fr[i + 1] = id[8 * i +: 8];
            u_rdr.fr[5] = p1;
            u_rdr.fr[6] = p2;
            u_rdr.fr[7] = 8'h01;
            u_rdr.fr[8] = p4;
            u_rdr.send(n, bad);
            repeat (3) @(posedge ref_clk);
            #1 chk("accept", eok, n_ok - o);
            chk("reject", erej, n_rej - r);
        end
    endtask
    // Request held three cycles: the repeats fall inside the answer.
    task answer(input [3:0] f, input s);
        reg [7:0] e [0:13];
        reg [15:0] c;
        begin
            fwi = f;
            slow = s;
            u_rdr.n_ans = 0;
            e[0] = 8'h50;
            for (i = 0; i < 4; i = i + 1) e[i + 1] = card_id[8 * i +: 8];
            for (i = 5; i < 9; i = i + 1) e[i] = 8'h00;
            e[9] = 8'h91;
            e[10] = 8'h81;
            e[11] = {f, 4'h0};
            c = 16'hffff;
            for (i = 0; i < 12; i = i + 1) c = u_rdr.crcb(c, e[i]);
            e[12] = ~c[7:0];
            e[13] = ~c[15:8];
            @(posedge ref_clk) #1 ans_req = 1'b1;
            repeat (3) @(posedge ref_clk);
            #1 ans_req = 1'b0;
            for (i = 0; i < 200 && u_rdr.n_ans < 14; i = i + 1) @(posedge ref_clk);
            repeat (6) @(posedge ref_clk);
            #1 chk("length", 14, u_rdr.n_ans);
            for (i = 0; i < 14; i = i + 1) chk("byte", e[i], u_rdr.ans[i]);
        end
    endtask
    // Watchdog sized well past the expected run.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch = n_mismatch + 1;
        $display("Watchdog expired");
        complete_run;
    end
    // Parameter table first, then answers, refusals and a mid-run reset.
    initial begin
        {reset_n, ans_req, state_clr, slow} = 4'h0;
        card_id = 32'h3c5a9617;
        fwi = 4'h0;
        rows[0] = {8'h00, 6'b000000};
        rows[1] = {8'h50, 6'b010100};
        rows[2] = {8'ha8, 6'b101010};
        rows[3] = {8'hf7, 6'b000001};
        rows[4] = {8'h6f, 6'b011011};
        repeat (20) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        for (k = 0; k < 5; k = k + 1) begin
            sel(rows[k][13:6], 8'h08, 8'h00, card_id, 9, 0, 1, 0);
            chk("tr0", rows[k][5:4], tr0);
            chk("tr1", rows[k][3:2], tr1);
            chk("eof_req", rows[k][1], eof_omit);
            chk("sof_req", rows[k][0], sof_omit);
            chk("active", 1, active);
            @(posedge ref_clk) #1 state_clr = 1'b1;
            @(posedge ref_clk) #1 state_clr = 1'b0;
            chk("cleared", 0, active);
        end
        answer(4'ha, 0);
        answer(4'h3, 1);
        sel(8'h00, 8'h08, 8'h00, card_id, 9, 1, 0, 0);
        sel(8'h00, 8'h08, 8'h00, card_id ^ 32'h100, 9, 0, 0, 0);
        sel(8'h00, 8'h08, 8'h00, card_id, 8, 0, 0, 0);
        chk("idle", 0, active);
        sel(8'ha8, 8'h08, 8'h00, card_id, 9, 0, 1, 0);
        sel(8'h00, 8'h18, 8'h00, card_id, 9, 0, 0, 1);
        sel(8'h00, 8'h08, 8'h01, card_id, 9, 0, 0, 1);
        chk("kept", 1, active);
        chk("kept_tr0", 2, tr0);
        reset_n = 1'b0;
        #10 chk("rst_active", 0, active);
        chk("rst_tr0", 8'h40, tr0_min);
        chk("rst_tr1", 8'h50, tr1_min);
        repeat (2) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        answer(4'hf, 0);
        complete_run;
    end
endmodule
bind typeb_atqb_attrib_handler typeb_atqb_attrib_handler_chk u_chk (
    .REF_CLK_I, .RESET_N_I, .RX_EOF_I, .ANS_REQ_I, .TX_READY_I, .FWI_I,
    .TX_VALID_O, .TX_DATA_O, .TX_LAST_O, .TX_SOF_EN_O, .TX_EOF_EN_O,
    .SEL_OK_O, .SEL_REJECT_O, .ACTIVE_O, .TR0_CODE_O, .TR1_CODE_O,
    .TR0_MIN_FS_O, .TR1_MIN_FS_O);
